// File: design/smct_pkg.sv
// Shared constants of the match/capture timer: offsets, fields, widths.
// Assumes a 32-bit register port with byte offsets, one word per register.
package smct_pkg;
	// ==========================================================
	// Widths
	localparam int CNT_W = 16; // Count, divider and compare width
	localparam int ADDR_W = 8; // Register port address width
	localparam int DATA_W = 32; // Register port data width
	localparam int NUM_CMP = 4; // Compare channels
	localparam int NUM_PIN = 3; // Widest set of compare pins
	localparam int NUM_FLAG = 5; // Pending-event flags
	// ==========================================================
	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_EVENT_FLAGS = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_RUN_CONTROL = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_MAIN_COUNT = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_DIVIDER_LIMIT = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_DIVIDER_COUNT = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_ACTION_CONTROL = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_COMPARE_0 = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_COMPARE_1 = 8'h1c;
	localparam logic [ADDR_W-1:0] OFS_COMPARE_2 = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_COMPARE_3 = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_SNAP_CONTROL = 8'h28;
	localparam logic [ADDR_W-1:0] OFS_SNAP_VALUE = 8'h2c;
	localparam logic [ADDR_W-1:0] OFS_EXT_CONTROL = 8'h3c;
	localparam logic [ADDR_W-1:0] OFS_SOURCE_SELECT = 8'h70;
	localparam logic [ADDR_W-1:0] OFS_PULSE_ENABLE = 8'h74;
	// ==========================================================
	// Field positions
	localparam int RUN_ENABLE_BIT = 0; // Counting enable
	localparam int RUN_RESET_BIT = 1; // Hold count and divider at zero
	localparam int RUN_W = 2;
	localparam int ACT_IRQ_BIT = 0; // Per channel: flag on match
	localparam int ACT_RESET_BIT = 1; // Per channel: reset count
	localparam int ACT_STOP_BIT = 2; // Per channel: stop count
	localparam int ACT_STRIDE = 3; // Bits per channel
	localparam int ACT_W = 12;
	localparam int SNAP_RISE_BIT = 0; // Snapshot on rising edge
	localparam int SNAP_FALL_BIT = 1; // Snapshot on falling edge
	localparam int SNAP_IRQ_BIT = 2; // Flag on snapshot
	localparam int SNAP_CTRL_W = 3;
	localparam int EXT_STATE_W = 4; // Output levels in bits 3:0
	localparam int EXT_ACT_LSB = 4; // Two action bits per channel
	localparam int EXT_ACT_W = 2;
	localparam int EXT_W = 12;
	localparam int SRC_MODE_LSB = 0; // Two mode bits
	localparam int SRC_SEL_LSB = 2; // Two input-select bits
	localparam int SRC_W = 4;
	localparam int FLAG_SNAP_BIT = 4; // Capture flag position
	// ==========================================================
	// Encodings
	localparam logic [1:0] MODE_TIMER = 2'h0;
	localparam logic [1:0] MODE_RISE = 2'h1;
	localparam logic [1:0] MODE_FALL = 2'h2;
	localparam logic [1:0] MODE_BOTH = 2'h3;
	localparam logic [1:0] SEL_SNAP_PIN = 2'h0; // Only input on offer
	localparam logic [1:0] EXT_NOTHING = 2'h0;
	localparam logic [1:0] EXT_LOW = 2'h1;
	localparam logic [1:0] EXT_HIGH = 2'h2;
	localparam logic [1:0] EXT_TOGGLE = 2'h3;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
endpackage : smct_pkg

// File: design/smct_timer.sv
// Sixteen-bit match/capture timer with its register bank.
// Assumes a single-cycle register port master and an asynchronous pin
// for snapshot input; compare pins feed the pad logic directly.
//
// Operation
// - Timer mode counts every limit-plus-one clocks
// - Divider climbs to limit, then clears, count increments
// - Run control disables counting or holds reset
// - Five readable event flags, cleared by writing
// - Compare match resets, stops, flags per channel
// - Qualifying snapshot pin edge captures the count
// - Software picks snapshot edges and flagging
// - Match toggles, lowers, raises or keeps output
// - Instance zero three outputs, instance one two
// - Source select: timer or counter with edges
// - Snapshot pin may serve as count clock
// - Pulse mode drives single-edge PWM outputs
// - All implemented register bits reset to zero
// - Instances identical apart from address and pinned output count
// - One clears a flag, zero leaves it
// - Flags at bits 3:0, capture bit 4
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module smct_timer #(
	parameter int NUM_OUT = 3 // Pinned outputs: 3 or 2
) (
	input wire logic clock_i, // 10 MHz clock
	input wire logic nrst_i, // Asynchronous reset, active low
	input wire logic [smct_pkg::ADDR_W-1:0] addr_i, // Byte offset
	input wire logic [smct_pkg::DATA_W-1:0] wdata_i, // Write data
	input wire logic wr_i, // Write strobe
	input wire logic rd_i, // Read strobe
	output logic [smct_pkg::DATA_W-1:0] rdata_o, // Read data, next cycle
	input wire logic snapshot_in_pin_i, // Asynchronous capture pin
	output logic [smct_pkg::NUM_PIN-1:0] compare_out_pin_o // Match pins
);
	import smct_pkg::*;

	// ==========================================================
	// Storage
	logic [RUN_W-1:0] run_ff; // Enable and reset bits
	logic [CNT_W-1:0] count_ff; // Main count
	logic [CNT_W-1:0] limit_ff; // Divider limit
	logic [CNT_W-1:0] div_ff; // Divider count
	logic [ACT_W-1:0] action_ff; // Per-channel match actions
	logic [CNT_W-1:0] cmp_ff [NUM_CMP]; // Compare values
	logic [SNAP_CTRL_W-1:0] snap_ctrl_ff; // Snapshot edges and flag
	logic [CNT_W-1:0] snap_ff; // Snapshot value
	logic [EXT_W-1:0] ext_ff; // Output levels and actions
	logic [SRC_W-1:0] src_ff; // Count source select
	logic [NUM_CMP-1:0] pulse_ff; // Pulse mode per channel
	logic [NUM_FLAG-1:0] flags_ff; // Pending events
	logic [DATA_W-1:0] rdata_ff; // Registered read answer
	logic [NUM_PIN-1:0] pin_ff; // Registered pin levels
	logic [2:0] sync_ff; // Two sync stages plus edge history

	// ==========================================================
	// Decode
	// Offsets only; the base address is decoded outside
	logic wr_flags, wr_run, wr_count, wr_limit, wr_div;
	logic wr_action, wr_snap_ctrl, wr_ext, wr_src, wr_pulse;
	logic [NUM_CMP-1:0] wr_cmp; // Compare value writes
	assign wr_flags = wr_i && (addr_i == OFS_EVENT_FLAGS);
	assign wr_run = wr_i && (addr_i == OFS_RUN_CONTROL);
	assign wr_count = wr_i && (addr_i == OFS_MAIN_COUNT);
	assign wr_limit = wr_i && (addr_i == OFS_DIVIDER_LIMIT);
	assign wr_div = wr_i && (addr_i == OFS_DIVIDER_COUNT);
	assign wr_action = wr_i && (addr_i == OFS_ACTION_CONTROL);
	assign wr_snap_ctrl = wr_i && (addr_i == OFS_SNAP_CONTROL);
	assign wr_ext = wr_i && (addr_i == OFS_EXT_CONTROL);
	assign wr_src = wr_i && (addr_i == OFS_SOURCE_SELECT);
	assign wr_pulse = wr_i && (addr_i == OFS_PULSE_ENABLE);
	assign wr_cmp[0] = wr_i && (addr_i == OFS_COMPARE_0);
	assign wr_cmp[1] = wr_i && (addr_i == OFS_COMPARE_1);
	assign wr_cmp[2] = wr_i && (addr_i == OFS_COMPARE_2);
	assign wr_cmp[3] = wr_i && (addr_i == OFS_COMPARE_3);

	// ==========================================================
	// Snapshot pin: sync and edges
	// Stage 0 is read only by stage 1; edges come from stages 1 and 2
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
			sync_ff <= 3'h0;
		else
			sync_ff <= {sync_ff[1:0], snapshot_in_pin_i};
	end

	logic pin_rise, pin_fall; // Synchronised edges
	assign pin_rise = sync_ff[1] && !sync_ff[2];
	assign pin_fall = !sync_ff[1] && sync_ff[2];

	// ==========================================================
	// Count source and tick
	logic [1:0] mode; // Timer or edge counting
	logic [1:0] in_sel; // Counter input selection
	logic src_edge; // Qualifying counter edge
	logic tick; // One unit of counting
	assign mode = src_ff[SRC_MODE_LSB +: 2];
	assign in_sel = src_ff[SRC_SEL_LSB +: 2];
	// Pin used as counting clock; unused selections never give a counter edge
	always_comb
	begin
		src_edge = 1'b0;
		if (in_sel == SEL_SNAP_PIN)
		begin
			case (mode)
				MODE_RISE: src_edge = pin_rise;
				MODE_FALL: src_edge = pin_fall;
				MODE_BOTH: src_edge = pin_rise || pin_fall;
				default: src_edge = 1'b0;
			endcase
		end
	end
	assign tick = (mode == MODE_TIMER) ? 1'b1 : src_edge;

	logic running; // Enabled and not held in reset
	logic inc_now; // Count advances this cycle
	assign running = run_ff[RUN_ENABLE_BIT] && !run_ff[RUN_RESET_BIT];
	assign inc_now = running && tick && (div_ff == limit_ff);

	// ==========================================================
	// Per-channel match decode
	logic [NUM_CMP-1:0] match; // Match at the counting moment
	logic [NUM_CMP-1:0] m_irq, m_reset, m_stop; // Enabled actions
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CMP; gi++)
		begin : g_match
			// Match is judged only when the count would step, so a
			// held count does not keep re-firing
			assign match[gi] = inc_now && (count_ff == cmp_ff[gi]);
			assign m_irq[gi] = match[gi] &&
				action_ff[gi*ACT_STRIDE + ACT_IRQ_BIT];
			assign m_reset[gi] = match[gi] &&
				action_ff[gi*ACT_STRIDE + ACT_RESET_BIT];
			assign m_stop[gi] = match[gi] &&
				action_ff[gi*ACT_STRIDE + ACT_STOP_BIT];
		end
	endgenerate

	// ==========================================================
	// Run control
	// A stop match wins over a same-cycle write that re-enables
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
			run_ff <= '0;
		else if (|m_stop)
			run_ff[RUN_ENABLE_BIT] <= 1'b0;
		else if (wr_run)
			run_ff <= wdata_i[RUN_W-1:0];
	end

	// ==========================================================
	// Main count
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
			count_ff <= CNT_ZERO;
		else if (run_ff[RUN_RESET_BIT])
			count_ff <= CNT_ZERO;
		else if (wr_count)
			count_ff <= wdata_i[CNT_W-1:0];
		else if (inc_now)
		begin
			if (|m_reset)
				count_ff <= CNT_ZERO;
			else if (|m_stop)
				count_ff <= count_ff; // Frozen at match value
			else
				count_ff <= count_ff + CNT_ONE;
		end
	end

	// ==========================================================
	// Divider
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
			div_ff <= CNT_ZERO;
		else if (run_ff[RUN_RESET_BIT])
			div_ff <= CNT_ZERO;
		else if (wr_div)
			div_ff <= wdata_i[CNT_W-1:0];
		else if (running && tick)
		begin
			// Limit below the count after a write still wraps at 16 bits
			if (div_ff == limit_ff)
				div_ff <= CNT_ZERO;
			else
				div_ff <= div_ff + CNT_ONE;
		end
	end

	// ==========================================================
	// Plain configuration registers
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			limit_ff <= CNT_ZERO;
			action_ff <= '0;
			snap_ctrl_ff <= '0;
			src_ff <= '0;
			pulse_ff <= '0;
		end
		else
		begin
			if (wr_limit)
				limit_ff <= wdata_i[CNT_W-1:0];
			if (wr_action)
				action_ff <= wdata_i[ACT_W-1:0];
			if (wr_snap_ctrl)
				snap_ctrl_ff <= wdata_i[SNAP_CTRL_W-1:0];
			if (wr_src)
				src_ff <= wdata_i[SRC_W-1:0];
			if (wr_pulse)
				pulse_ff <= wdata_i[NUM_CMP-1:0];
		end
	end

	generate
		for (gi = 0; gi < NUM_CMP; gi++)
		begin : g_cmp
			// Compare value store
			always_ff @(posedge clock_i or negedge nrst_i)
			begin
				if (!nrst_i)
					cmp_ff[gi] <= CNT_ZERO;
				else if (wr_cmp[gi])
					cmp_ff[gi] <= wdata_i[CNT_W-1:0];
			end
		end
	endgenerate

	// ==========================================================
	// Snapshot capture
	logic snap_evt; // Qualifying snapshot edge
	assign snap_evt = (pin_rise && snap_ctrl_ff[SNAP_RISE_BIT]) ||
		(pin_fall && snap_ctrl_ff[SNAP_FALL_BIT]);
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
			snap_ff <= CNT_ZERO;
		else if (snap_evt)
			snap_ff <= count_ff;
	end

	// ==========================================================
	// Event flags
	logic [NUM_FLAG-1:0] flag_set; // Hardware set terms
	assign flag_set = {snap_evt && snap_ctrl_ff[SNAP_IRQ_BIT], m_irq};
	// Set wins over a same-cycle clear so no event is lost
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
			flags_ff <= '0;
		else if (wr_flags)
			flags_ff <= (flags_ff & ~wdata_i[NUM_FLAG-1:0]) |
				flag_set;
		else
			flags_ff <= flags_ff | flag_set;
	end

	// ==========================================================
	// External output control
	logic [EXT_STATE_W-1:0] nxt_state; // Levels after match actions
	always_comb
	begin
		nxt_state = wr_ext ? wdata_i[EXT_STATE_W-1:0] :
			ext_ff[EXT_STATE_W-1:0];
		for (int i = 0; i < NUM_CMP; i++)
		begin
			if (match[i])
			begin
				case (ext_ff[EXT_ACT_LSB + i*EXT_ACT_W +: EXT_ACT_W])
					EXT_LOW: nxt_state[i] = 1'b0;
					EXT_HIGH: nxt_state[i] = 1'b1;
					EXT_TOGGLE: nxt_state[i] = !ext_ff[i];
					default: nxt_state[i] = ext_ff[i];
				endcase
			end
		end
	end
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
			ext_ff <= '0;
		else if (wr_ext)
			ext_ff <= {wdata_i[EXT_W-1:EXT_STATE_W], nxt_state};
		else
			ext_ff[EXT_STATE_W-1:0] <= nxt_state;
	end

	// ==========================================================
	// Compare pins
	// Pulse mode: low below the compare value, high from it on; the
	// period comes from a resetting match on an unpinned channel
	generate
		for (gi = 0; gi < NUM_PIN; gi++)
		begin : g_pin
			always_ff @(posedge clock_i or negedge nrst_i)
			begin
				if (!nrst_i)
					pin_ff[gi] <= 1'b0;
				else if (gi >= NUM_OUT)
					pin_ff[gi] <= 1'b0;
				else if (pulse_ff[gi])
					pin_ff[gi] <= (count_ff >= cmp_ff[gi]);
				else
					pin_ff[gi] <= ext_ff[gi];
			end
		end
	endgenerate
	assign compare_out_pin_o = pin_ff;

	// ==========================================================
	// Read path: answer in the cycle after the strobe
	logic [DATA_W-1:0] rd_mux; // Selected register, zero extended
	always_comb
	begin
		rd_mux = DATA_ZERO;
		case (addr_i)
			OFS_EVENT_FLAGS: rd_mux[NUM_FLAG-1:0] = flags_ff;
			OFS_RUN_CONTROL: rd_mux[RUN_W-1:0] = run_ff;
			OFS_MAIN_COUNT: rd_mux[CNT_W-1:0] = count_ff;
			OFS_DIVIDER_LIMIT: rd_mux[CNT_W-1:0] = limit_ff;
			OFS_DIVIDER_COUNT: rd_mux[CNT_W-1:0] = div_ff;
			OFS_ACTION_CONTROL: rd_mux[ACT_W-1:0] = action_ff;
			OFS_COMPARE_0: rd_mux[CNT_W-1:0] = cmp_ff[0];
			OFS_COMPARE_1: rd_mux[CNT_W-1:0] = cmp_ff[1];
			OFS_COMPARE_2: rd_mux[CNT_W-1:0] = cmp_ff[2];
			OFS_COMPARE_3: rd_mux[CNT_W-1:0] = cmp_ff[3];
			OFS_SNAP_CONTROL: rd_mux[SNAP_CTRL_W-1:0] = snap_ctrl_ff;
			OFS_SNAP_VALUE: rd_mux[CNT_W-1:0] = snap_ff;
			OFS_EXT_CONTROL: rd_mux[EXT_W-1:0] = ext_ff;
			OFS_SOURCE_SELECT: rd_mux[SRC_W-1:0] = src_ff;
			OFS_PULSE_ENABLE: rd_mux[NUM_CMP-1:0] = pulse_ff;
			default: rd_mux = DATA_ZERO; // Unmapped reads zero
		endcase
	end
	// Data held only for the answer cycle, zero otherwise
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
			rdata_ff <= DATA_ZERO;
		else if (rd_i)
			rdata_ff <= rd_mux;
		else
			rdata_ff <= DATA_ZERO;
	end
	assign rdata_o = rdata_ff;

	// ==========================================================
	// Assertions
	sequence s_read_count;
		rd_i && (addr_i == OFS_MAIN_COUNT);
	endsequence
	sequence s_answer_count;
		##1 (rdata_o[CNT_W-1:0] == $past(count_ff));
	endsequence
	property p_read_count;
		@(posedge clock_i) disable iff (!nrst_i)
		s_read_count |-> s_answer_count;
	endproperty
	a_read_count: assert property (p_read_count)
		else $error("Count read answer wrong");

	property p_div_wrap;
		@(posedge clock_i) disable iff (!nrst_i)
		(inc_now && !wr_i) |=> (div_ff == CNT_ZERO);
	endproperty
	a_div_wrap: assert property (p_div_wrap)
		else $error("Divider did not clear at limit");

	property p_count_step;
		@(posedge clock_i) disable iff (!nrst_i)
		(inc_now && !wr_i && !(|m_reset) && !(|m_stop)) |=>
			(count_ff == $past(count_ff) + CNT_ONE);
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("Count did not step by one");

	property p_hold_reset;
		@(posedge clock_i) disable iff (!nrst_i)
		(run_ff[RUN_RESET_BIT] && !wr_i) [*2] |->
			(count_ff == CNT_ZERO) && (div_ff == CNT_ZERO);
	endproperty
	a_hold_reset: assert property (p_hold_reset)
		else $error("Count not held at zero in reset");

	property p_stop_clears;
		@(posedge clock_i) disable iff (!nrst_i)
		(|m_stop) |=> !run_ff[RUN_ENABLE_BIT] &&
			(count_ff == $past(count_ff) || $past(|m_reset));
	endproperty
	a_stop_clears: assert property (p_stop_clears)
		else $error("Stop match did not freeze counting");

	property p_flag_set_wins;
		@(posedge clock_i) disable iff (!nrst_i)
		flag_set[0] |=> flags_ff[0];
	endproperty
	a_flag_set_wins: assert property (p_flag_set_wins)
		else $error("Match flag lost");

	property p_flag_clear;
		@(posedge clock_i) disable iff (!nrst_i)
		(wr_flags && wdata_i[FLAG_SNAP_BIT] && !flag_set[FLAG_SNAP_BIT])
			|=> !flags_ff[FLAG_SNAP_BIT];
	endproperty
	a_flag_clear: assert property (p_flag_clear)
		else $error("Capture flag not cleared by one");

	property p_snapshot;
		@(posedge clock_i) disable iff (!nrst_i)
		snap_evt |=> (snap_ff == $past(count_ff));
	endproperty
	a_snapshot: assert property (p_snapshot)
		else $error("Snapshot missed the count");

	property p_toggle;
		@(posedge clock_i) disable iff (!nrst_i)
		(match[0] && !wr_ext &&
			ext_ff[EXT_ACT_LSB +: EXT_ACT_W] == EXT_TOGGLE) |=>
			(ext_ff[0] != $past(ext_ff[0]));
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("Output did not toggle on match");

	property p_pulse_pin;
		@(posedge clock_i) disable iff (!nrst_i)
		(pulse_ff[0] && count_ff < cmp_ff[0]) |=> !compare_out_pin_o[0];
	endproperty
	a_pulse_pin: assert property (p_pulse_pin)
		else $error("Pulse pin high below compare value");
endmodule : smct_timer

// File: dv/smct_tb.sv
// Self-checking bench for the match/capture timer, both pin widths.
// Assumes the register port answers reads in the next cycle only.
`timescale 1ns/1ps
module testbench;
	import smct_pkg::*;
	// ==========================================================
	// Signals
	logic clock_i; // 10 MHz bench clock
	logic nrst_i; // Reset, active low
	logic wr_i; // Write strobe
	logic rd_i; // Read strobe
	logic pin; // Snapshot pin level
	logic [ADDR_W-1:0] addr; // Register offset
	logic [DATA_W-1:0] wdata; // Write data
	logic [DATA_W-1:0] rdata; // Read data, wide instance
	logic [DATA_W-1:0] rdata_b; // Read data, narrow instance
	logic [DATA_W-1:0] got_b; // Last value read, narrow instance
	logic [DATA_W-1:0] got; // Last value read
	logic [NUM_PIN-1:0] cmp_pin; // Pins, three-output instance
	logic [NUM_PIN-1:0] cmp_pin_b; // Pins, two-output instance
	int errors; // Mismatches
	int n_checks; // Comparisons
	// Every mapped offset, for the reset sweep
	logic [ADDR_W-1:0] ofs_list [15] = '{OFS_EVENT_FLAGS, OFS_RUN_CONTROL,
		OFS_MAIN_COUNT, OFS_DIVIDER_LIMIT, OFS_DIVIDER_COUNT,
		OFS_ACTION_CONTROL, OFS_COMPARE_0, OFS_COMPARE_1, OFS_COMPARE_2,
		OFS_COMPARE_3, OFS_SNAP_CONTROL, OFS_SNAP_VALUE, OFS_EXT_CONTROL,
		OFS_SOURCE_SELECT, OFS_PULSE_ENABLE};
	// ==========================================================
	// Clock and instances
	// Both instances share one bus so writes land in both
	always #50 clock_i = ~clock_i;
	smct_timer #(.NUM_OUT(3)) dut (.clock_i(clock_i), .nrst_i(nrst_i),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata), .snapshot_in_pin_i(pin),
		.compare_out_pin_o(cmp_pin));
	smct_timer #(.NUM_OUT(2)) dut_b (.clock_i(clock_i), .nrst_i(nrst_i),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_b), .snapshot_in_pin_i(pin),
		.compare_out_pin_o(cmp_pin_b));
	// ==========================================================
	// Shared tasks
	task summarize;
		if (errors == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize
	task chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
		n_checks++;
		if (g !== e)
		begin
			errors++;
			$display("[ERR] %0t value %h expected %h", $time, g, e);
		end
	endtask : chk
	task chk1(input logic g, input logic e);
		n_checks++;
		if (g !== e)
		begin
			errors++;
			$display("[ERR] %0t bit %b expected %b", $time, g, e);
		end
	endtask : chk1
	// One-cycle write strobe
	task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clock_i);
		wr_i <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask : wr
	// Data stand only in the cycle after the strobe
	task rd(input logic [ADDR_W-1:0] a);
		@(posedge clock_i);
		rd_i <= 1'b1;
		addr <= a;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 got = rdata;
		got_b = rdata_b;
	endtask : rd
	// Bounded poll; running out ends the run
	task poll(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m,
		input logic [DATA_W-1:0] v);
		for (int i = 0; i < 200; i++)
		begin
			rd(a);
			if ((got & m) === v)
				return;
		end
		errors++;
		$display("[ERR] %0t poll timed out", $time);
		summarize();
	endtask : poll
	// Pin level held long enough to pass the synchroniser
	task set_pin(input logic v);
		@(posedge clock_i);
		pin <= v;
		repeat (8) @(posedge clock_i);
	endtask : set_pin
	// ==========================================================
	// Scenarios
	task t_reset;
		foreach (ofs_list[i])
		begin
			rd(ofs_list[i]);
			chk(got, DATA_ZERO);
		end
		rd(8'h40);
		chk(got, DATA_ZERO);
		chk(32'(cmp_pin), DATA_ZERO);
	endtask : t_reset
	task t_prescale;
		logic [DATA_W-1:0] c0;
		wr(OFS_DIVIDER_LIMIT, 32'h2);
		wr(OFS_RUN_CONTROL, 32'h1);
		rd(OFS_MAIN_COUNT);
		c0 = got;
		// Sampling edges 30 clocks apart: ten counts at limit 2
		repeat (28) @(posedge clock_i);
		rd(OFS_MAIN_COUNT);
		chk(got - c0, 32'ha);
		wr(OFS_RUN_CONTROL, 32'h3);
		rd(OFS_MAIN_COUNT);
		chk(got, DATA_ZERO);
		rd(OFS_DIVIDER_COUNT);
		chk(got, DATA_ZERO);
		wr(OFS_RUN_CONTROL, 32'h0);
		repeat (10) @(posedge clock_i);
		rd(OFS_MAIN_COUNT);
		chk(got, DATA_ZERO);
	endtask : t_prescale
	task t_match;
		wr(OFS_DIVIDER_LIMIT, 32'h0);
		wr(OFS_COMPARE_0, 32'h5);
		wr(OFS_ACTION_CONTROL, 32'h3);
		wr(OFS_RUN_CONTROL, 32'h1);
		poll(OFS_EVENT_FLAGS, 32'h1, 32'h1);
		for (int i = 0; i < 12; i++)
		begin
			rd(OFS_MAIN_COUNT);
			chk1(got <= 32'h5, 1'b1);
		end
		wr(OFS_RUN_CONTROL, 32'h0);
		wr(OFS_EVENT_FLAGS, 32'h1e);
		rd(OFS_EVENT_FLAGS);
		chk(got, 32'h1);
		wr(OFS_EVENT_FLAGS, 32'h1);
		rd(OFS_EVENT_FLAGS);
		chk(got, DATA_ZERO);
	endtask : t_match
	task t_stop;
		wr(OFS_MAIN_COUNT, 32'h0);
		wr(OFS_COMPARE_1, 32'h7);
		wr(OFS_ACTION_CONTROL, 32'h28);
		wr(OFS_RUN_CONTROL, 32'h1);
		poll(OFS_RUN_CONTROL, 32'h1, 32'h0);
		repeat (10) @(posedge clock_i);
		rd(OFS_MAIN_COUNT);
		chk(got, 32'h7);
		chk(got_b, 32'h7);
		rd(OFS_EVENT_FLAGS);
		chk(got, 32'h2);
		wr(OFS_EVENT_FLAGS, 32'h2);
	endtask : t_stop
	task t_ext;
		// Each row: preset level, action code, level after one match
		logic [3:0] tbl [4];
		tbl = '{4'b1_00_1, 4'b1_01_0, 4'b0_10_1, 4'b0_11_1};
		wr(OFS_COMPARE_0, 32'h3);
		wr(OFS_ACTION_CONTROL, 32'h4);
		foreach (tbl[i])
		begin
			wr(OFS_RUN_CONTROL, 32'h2);
			wr(OFS_EXT_CONTROL, {26'h0, tbl[i][2:1], 3'h0, tbl[i][3]});
			wr(OFS_RUN_CONTROL, 32'h1);
			poll(OFS_RUN_CONTROL, 32'h1, 32'h0);
			repeat (2) @(posedge clock_i);
			#1;
			chk1(cmp_pin[0], tbl[i][0]);
		end
		wr(OFS_EXT_CONTROL, 32'h5);
		repeat (2) @(posedge clock_i);
		#1;
		chk1(cmp_pin[2], 1'b1);
		chk1(cmp_pin[1], 1'b0);
		chk1(cmp_pin_b[2], 1'b0);
		chk1(cmp_pin_b[0], 1'b1);
	endtask : t_ext
	task t_snap;
		wr(OFS_ACTION_CONTROL, 32'h0);
		wr(OFS_MAIN_COUNT, 32'h1234);
		wr(OFS_SNAP_CONTROL, 32'h5);
		set_pin(1'b1);
		poll(OFS_EVENT_FLAGS, 32'h10, 32'h10);
		rd(OFS_SNAP_VALUE);
		chk(got, 32'h1234);
		wr(OFS_MAIN_COUNT, 32'h55);
		wr(OFS_SNAP_VALUE, 32'h0);
		set_pin(1'b0);
		rd(OFS_SNAP_VALUE);
		chk(got, 32'h1234);
		wr(OFS_EVENT_FLAGS, 32'h10);
		wr(OFS_SNAP_CONTROL, 32'h2);
		wr(OFS_MAIN_COUNT, 32'h66);
		set_pin(1'b1);
		set_pin(1'b0);
		rd(OFS_SNAP_VALUE);
		chk(got, 32'h66);
		rd(OFS_EVENT_FLAGS);
		chk(got, DATA_ZERO);
	endtask : t_snap
	task t_counter;
		wr(OFS_SNAP_CONTROL, 32'h0);
		wr(OFS_MAIN_COUNT, 32'h0);
		wr(OFS_SOURCE_SELECT, 32'(MODE_RISE));
		wr(OFS_RUN_CONTROL, 32'h1);
		repeat (4)
		begin
			set_pin(1'b1);
			set_pin(1'b0);
		end
		rd(OFS_MAIN_COUNT);
		chk(got, 32'h4);
		wr(OFS_SOURCE_SELECT, 32'(MODE_BOTH));
		set_pin(1'b1);
		set_pin(1'b0);
		wr(OFS_SOURCE_SELECT, 32'(MODE_FALL));
		set_pin(1'b1);
		set_pin(1'b0);
		rd(OFS_MAIN_COUNT);
		chk(got, 32'h7);
		// In edge-counting mode an input selection other than the pin never counts
		wr(OFS_SOURCE_SELECT, 32'h5);
		set_pin(1'b1);
		set_pin(1'b0);
		rd(OFS_MAIN_COUNT);
		chk(got, 32'h7);
		wr(OFS_RUN_CONTROL, 32'h0);
		wr(OFS_SOURCE_SELECT, 32'(MODE_TIMER));
	endtask : t_counter
	task t_pwm;
		int h;
		h = 0;
		wr(OFS_RUN_CONTROL, 32'h2);
		wr(OFS_COMPARE_0, 32'h4);
		// Period set by channel 3, which has no pin
		wr(OFS_COMPARE_3, 32'h9);
		wr(OFS_ACTION_CONTROL, 32'h400);
		wr(OFS_PULSE_ENABLE, 32'h1);
		wr(OFS_RUN_CONTROL, 32'h1);
		repeat (20) @(posedge clock_i);
		// Period ten, high from 4 to 9: thirty of fifty cycles
		repeat (50)
		begin
			@(posedge clock_i);
			#1 if (cmp_pin[0] === 1'b1) h++;
		end
		chk(32'(h), 32'd30);
	endtask : t_pwm
	// ==========================================================
	// Main sequence
	initial
	begin
		clock_i = 1'b0;
		nrst_i = 1'b0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		pin = 1'b0;
		addr = '0;
		wdata = '0;
		got = '0;
		errors = 0;
		n_checks = 0;
		repeat (8) @(posedge clock_i);
		nrst_i <= 1'b1;
		t_reset();
		t_prescale();
		t_match();
		t_stop();
		t_ext();
		t_snap();
		t_counter();
		t_pwm();
		summarize();
	end
endmodule : testbench
